// >>> rtl/adc_dma_capture.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "adc_regs.svh"
module adc_dma_capture
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic CONV_START,
    output logic [3:0] CONV_CH,
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_DATA,
    input wire logic EXT_TRIG,
    input wire logic [7:0] CORE_P0_O,
    input wire logic CORE_P0_OE,
    input wire logic [7:0] CORE_P2_O,
    output logic [7:0] P0_O,
    output logic P0_OE,
    input wire logic [7:0] P0_I,
    output logic [7:0] P2_O,
    output logic [7:0] MEM_ADDR_LO,
    output logic [7:0] MEM_ADDR_PG,
    output logic MEM_WE_N,
    output logic MEM_RD_N,
    output logic IRQ
);

localparam logic [15:0] MIN_CYC = 16'(`ADC_SAMPLE_MIN_CYC);

adc_pkg::adc_state_t state_q;
adc_pkg::adc_mem_req_t mem_q;
adc_pkg::adc_result_t res_q;
logic [7:0] ctl1_q;
logic dma_en_q;
logic single_q;
logic [3:0] ctl2_ch_q;
logic [23:0] ptr_q;
logic [1:0] irq_st_q;
logic [1:0] irq_msk_q;
logic [3:0] cur_ch_q;
logic [15:0] tmr_q;
logic tick;
logic [15:0] period;
logic wr_go;
logic bvalid_q;
logic [1:0] bresp_q;
logic rvalid_q;
logic [31:0] rdata_q;
logic [1:0] rresp_q;
logic table_done;
logic single_done;
logic conv_start_q;
logic conv_pending_q;
logic dma_active;

function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a[7:2] == ofs[7:2]);
endfunction

function automatic logic [7:0] lane0(input logic [31:0] d);
    lane0 = d[7:0];
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus slave: both channels taken together, so order does not matter

assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
assign S_AXI_AWREADY = wr_go;
assign S_AXI_WREADY = wr_go;
assign S_AXI_BVALID = bvalid_q;
assign S_AXI_BRESP = bresp_q;
assign S_AXI_ARREADY = !rvalid_q;
assign S_AXI_RVALID = rvalid_q;
assign S_AXI_RDATA = rdata_q;
assign S_AXI_RRESP = rresp_q;

function automatic logic mapped(input logic [7:0] a);
    mapped = addr_hit(a, `ADC_OFS_CTL1) || addr_hit(a, `ADC_OFS_CTL2)
        || addr_hit(a, `ADC_OFS_RES_LO) || addr_hit(a, `ADC_OFS_RES_HI)
        || addr_hit(a, `ADC_OFS_PTR_LO) || addr_hit(a, `ADC_OFS_PTR_HI)
        || addr_hit(a, `ADC_OFS_PTR_PG) || addr_hit(a, `ADC_OFS_IRQ_ST)
        || addr_hit(a, `ADC_OFS_IRQ_MSK);
endfunction

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        bvalid_q <= 1'b0;
        bresp_q <= `ADC_RESP_OKAY;
    end
    else if (wr_go)
    begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(S_AXI_AWADDR) ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
        bvalid_q <= 1'b0;
    end
end

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        rvalid_q <= 1'b0;
        rdata_q <= 32'h0000_0000;
        rresp_q <= `ADC_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid_q)
    begin
        rvalid_q <= 1'b1;
        rresp_q <= mapped(S_AXI_ARADDR) ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
        rdata_q <= 32'h0000_0000;
        if (addr_hit(S_AXI_ARADDR, `ADC_OFS_CTL1))
            rdata_q[7:0] <= ctl1_q;
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_CTL2))
            rdata_q[7:0] <= {irq_st_q[`ADC_IRQ_TABLE], dma_en_q, 1'b0, single_q, ctl2_ch_q};
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_RES_LO))
            rdata_q[7:0] <= res_q.value[7:0]; // [RULE_01]
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_RES_HI))
            rdata_q[7:0] <= {res_q.ch, res_q.value[11:8]}; // [RULE_01]
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_PTR_LO))
            rdata_q[7:0] <= ptr_q[7:0];
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_PTR_HI))
            rdata_q[7:0] <= ptr_q[15:8];
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_PTR_PG))
            rdata_q[7:0] <= ptr_q[23:16];
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_IRQ_ST))
            rdata_q[1:0] <= irq_st_q;
        else if (addr_hit(S_AXI_ARADDR, `ADC_OFS_IRQ_MSK))
            rdata_q[1:0] <= irq_msk_q;
    end
    else if (S_AXI_RREADY)
    begin
        rvalid_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers

logic wr_ctl2;
assign wr_ctl2 = wr_go && S_AXI_WSTRB[0] && addr_hit(S_AXI_AWADDR, `ADC_OFS_CTL2);

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        ctl1_q <= `ADC_RST_BYTE;
        irq_msk_q <= 2'h0;
        ctl2_ch_q <= 4'h0;
    end
    else if (wr_go && S_AXI_WSTRB[0])
    begin
        if (addr_hit(S_AXI_AWADDR, `ADC_OFS_CTL1))
            ctl1_q <= lane0(S_AXI_WDATA);
        if (addr_hit(S_AXI_AWADDR, `ADC_OFS_IRQ_MSK))
            irq_msk_q <= S_AXI_WDATA[1:0];
        if (wr_ctl2)
            ctl2_ch_q <= S_AXI_WDATA[3:0];
    end
end

// enable clears itself when the stop code is fetched
always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        dma_en_q <= 1'b0;
    else if (state_q == adc_pkg::ST_CHECK && P0_I[7:4] == `ADC_CH_STOP)
        dma_en_q <= 1'b0; // [RULE_15] [RULE_07]
    else if (wr_ctl2)
        dma_en_q <= S_AXI_WDATA[`ADC_CTL2_DMA]; // [RULE_03]
end

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        single_q <= 1'b0;
    else if (single_done)
        single_q <= 1'b0;
    else if (wr_ctl2 && !S_AXI_WDATA[`ADC_CTL2_DMA])
        single_q <= S_AXI_WDATA[`ADC_CTL2_SINGLE];
end

// pointer bytes are separate registers; hardware advance wins over a write
always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        ptr_q <= 24'h000000;
    else if (state_q == adc_pkg::ST_WR_LO)
        ptr_q <= ptr_q + `ADC_ENTRY_BYTES; // [RULE_14]
    else if (wr_go && S_AXI_WSTRB[0] && !dma_en_q)
    begin
        if (addr_hit(S_AXI_AWADDR, `ADC_OFS_PTR_LO))
            ptr_q[7:0] <= lane0(S_AXI_WDATA); // [RULE_06]
        if (addr_hit(S_AXI_AWADDR, `ADC_OFS_PTR_HI))
            ptr_q[15:8] <= lane0(S_AXI_WDATA);
        if (addr_hit(S_AXI_AWADDR, `ADC_OFS_PTR_PG))
            ptr_q[23:16] <= lane0(S_AXI_WDATA);
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts: set wins over write-one-to-clear

assign table_done = state_q == adc_pkg::ST_CHECK && P0_I[7:4] == `ADC_CH_STOP;
assign single_done = !dma_en_q && conv_pending_q && CONV_DONE;

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        irq_st_q <= 2'h0;
    else
    begin
        for (int i = 0; i < 2; i++)
        begin
            if ((i == `ADC_IRQ_TABLE && table_done) || (i == `ADC_IRQ_SINGLE && single_done))
                irq_st_q[i] <= 1'b1; // [RULE_10]
            else if (wr_go && S_AXI_WSTRB[0] && addr_hit(S_AXI_AWADDR, `ADC_OFS_IRQ_ST)
                     && S_AXI_WDATA[i])
                irq_st_q[i] <= 1'b0;
        end
    end
end

assign IRQ = |(irq_st_q & irq_msk_q); // [RULE_10]

////////////////////////////////////////////////////////////////////////////////
// sample timer: period is a multiple of the 5 us minimum, zero means unset

assign period = 16'(ctl1_q[6:0]) * MIN_CYC; // [RULE_02]

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        tmr_q <= 16'h0000;
    else if (period == 16'h0000 || tmr_q >= period - 16'h0001)
        tmr_q <= 16'h0000;
    else
        tmr_q <= tmr_q + 16'h0001;
end

// external trigger still respects the 5 us floor through the timer gate
assign tick = period != 16'h0000 // [RULE_09]
    && (ctl1_q[`ADC_CTL1_EXTTRIG] ? EXT_TRIG && tmr_q == 16'h0000
                                  : tmr_q == period - 16'h0001);

////////////////////////////////////////////////////////////////////////////////
// capture sequencer

assign dma_active = dma_en_q || state_q != adc_pkg::ST_IDLE;

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        state_q <= adc_pkg::ST_IDLE;
    else
    begin
        unique case (state_q)
            adc_pkg::ST_IDLE:
                if (dma_en_q)
                    state_q <= adc_pkg::ST_FETCH; // [RULE_08]
            adc_pkg::ST_FETCH:
                if (mem_q.re)
                    state_q <= adc_pkg::ST_CHECK;
            adc_pkg::ST_CHECK:
                if (P0_I[7:4] == `ADC_CH_STOP)
                    state_q <= adc_pkg::ST_IDLE; // [RULE_15]
                else
                    state_q <= adc_pkg::ST_TRIG;
            adc_pkg::ST_TRIG:
                if (tick)
                    state_q <= adc_pkg::ST_CONV;
            adc_pkg::ST_CONV:
                if (CONV_DONE)
                    state_q <= adc_pkg::ST_WR_HI; // [RULE_04]
            adc_pkg::ST_WR_HI:
                state_q <= adc_pkg::ST_WR_LO;
            adc_pkg::ST_WR_LO:
                state_q <= adc_pkg::ST_FETCH; // [RULE_14]
        endcase
    end
end

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        cur_ch_q <= 4'h0;
    else if (state_q == adc_pkg::ST_CHECK)
        cur_ch_q <= P0_I[7:4]; // [RULE_14]
    else if (!dma_active && wr_ctl2)
        cur_ch_q <= S_AXI_WDATA[3:0];
end

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        conv_start_q <= 1'b0;
        conv_pending_q <= 1'b0;
    end
    else
    begin
        conv_start_q <= (state_q == adc_pkg::ST_TRIG && tick)
            || (!dma_active && single_q && !conv_pending_q && !conv_start_q && tick);
        if (CONV_DONE)
            conv_pending_q <= 1'b0;
        else if (conv_start_q)
            conv_pending_q <= 1'b1;
    end
end

assign CONV_START = conv_start_q;
assign CONV_CH = cur_ch_q;

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        res_q <= '0;
    else if (CONV_DONE && conv_pending_q)
    begin
        res_q.ch <= cur_ch_q; // [RULE_01] [RULE_11]
        res_q.value <= CONV_DATA;
    end
end

// memory cycles: high byte of an entry first, low byte next
// read strobe lasts one cycle and sram answers a cycle later, so fetch waits for it
always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        mem_q <= '0;
    else
    begin
        mem_q.addr <= ptr_q;
        mem_q.re <= (state_q == adc_pkg::ST_FETCH && !mem_q.re)
            || (state_q == adc_pkg::ST_IDLE && dma_en_q);
        mem_q.we <= state_q == adc_pkg::ST_WR_HI || state_q == adc_pkg::ST_WR_LO;
        mem_q.wdata <= 8'h00;
        if (state_q == adc_pkg::ST_WR_HI)
            mem_q.wdata <= {res_q.ch, res_q.value[11:8]}; // [RULE_11]
        else if (state_q == adc_pkg::ST_WR_LO)
        begin
            mem_q.wdata <= res_q.value[7:0];
            mem_q.addr <= ptr_q + 24'h000001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// port muxing: core keeps running, but during capture its port writes go nowhere

always_comb
begin
    if (dma_active)
    begin
        P0_O = mem_q.we ? mem_q.wdata : mem_q.addr[7:0]; // [RULE_13]
        P0_OE = mem_q.we;
        P2_O = mem_q.addr[15:8];
    end
    else
    begin
        P0_O = CORE_P0_O; // [RULE_12]
        P0_OE = CORE_P0_OE;
        P2_O = CORE_P2_O;
    end
end

assign MEM_ADDR_LO = mem_q.addr[7:0];
assign MEM_ADDR_PG = mem_q.addr[23:16];
assign MEM_WE_N = !mem_q.we;
assign MEM_RD_N = !mem_q.re;

////////////////////////////////////////////////////////////////////////////////
// checks

logic [15:0] since_q;
always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
        since_q <= 16'hFFFF;
    else if (conv_start_q)
        since_q <= 16'h0001;
    else if (since_q != 16'hFFFF)
        since_q <= since_q + 16'h0001;
end

property p_rate;
    @(posedge CLK) disable iff (!RSTN) conv_start_q |-> since_q >= MIN_CYC;
endproperty
a_rate: assert property (p_rate) else $error("samples closer than 5 us"); // [RULE_02]

property p_stop;
    @(posedge CLK) disable iff (!RSTN) table_done |=> !dma_en_q && state_q == adc_pkg::ST_IDLE
        && !mem_q.we;
endproperty
a_stop: assert property (p_stop) else $error("stop code did not end capture"); // [RULE_15]

property p_done;
    @(posedge CLK) disable iff (!RSTN) table_done ##1 irq_msk_q[`ADC_IRQ_TABLE] |-> IRQ;
endproperty
a_done: assert property (p_done) else $error("table end gave no interrupt"); // [RULE_10]

property p_gate;
    @(posedge CLK) disable iff (!RSTN)
        dma_active |-> P0_OE == mem_q.we && P2_O == mem_q.addr[15:8];
endproperty
a_gate: assert property (p_gate) else $error("core drove port 0 during capture"); // [RULE_13]

property p_adv;
    @(posedge CLK) disable iff (!RSTN)
        state_q == adc_pkg::ST_WR_LO |=> ptr_q == $past(ptr_q) + `ADC_ENTRY_BYTES;
endproperty
a_adv: assert property (p_adv) else $error("pointer did not advance by two"); // [RULE_14]

property p_tag;
    @(posedge CLK) disable iff (!RSTN)
        state_q == adc_pkg::ST_WR_HI |=> mem_q.we && mem_q.wdata[7:4] == cur_ch_q;
endproperty
a_tag: assert property (p_tag) else $error("written result lost channel code"); // [RULE_11]

property p_unset;
    @(posedge CLK) disable iff (!RSTN) ctl1_q[6:0] == 7'h00 |=> !conv_start_q;
endproperty
a_unset: assert property (p_unset) else $error("converted with timing unset"); // [RULE_09]

property p_write;
    @(posedge CLK) disable iff (!RSTN)
        state_q == adc_pkg::ST_CONV && CONV_DONE |=> ##1 mem_q.we ##1 mem_q.we;
endproperty
a_write: assert property (p_write) else $error("result not written to memory"); // [RULE_04]

property p_start;
    @(posedge CLK) disable iff (!RSTN)
        state_q == adc_pkg::ST_IDLE && dma_en_q |=> !MEM_RD_N && MEM_ADDR_LO == ptr_q[7:0];
endproperty
a_start: assert property (p_start) else $error("capture did not start at pointer"); // [RULE_08]

endmodule

// >>> rtl/adc_regs.svh
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
// Functional notes
// RULE_01: result pair holds 12-bit value, channel code in top four high-byte bits.
// RULE_02: samples no faster than one per 5 us, 200 kHz.
// RULE_03: setting dma_capture_enable starts continuous sampling per control registers.
// RULE_04: capture writes every result to external RAM without core action.
// RULE_05: software fills table channel codes in entry top nibbles first.
// RULE_06: software loads pointer low, then high, then page byte.
// RULE_07: channel code 1111 ends the table and acts as stop command.
// RULE_08: enabled capture converts and stores results sequentially from start pointer.
// RULE_09: software sets timing and trigger before enabling, else no progress.
// RULE_10: table end sets conversion_done_flag and interrupts the core.
// RULE_11: written-back results keep channel code in top four bits.
// RULE_12: core keeps running during capture.
// RULE_13: core port 0 and 2 accesses drive no pins during capture.
// RULE_14: pointer advances by two bytes; next entry code picks next channel.
// RULE_15: stop fetch means no conversion, no write, capture state cleared.

// register byte offsets
`define ADC_OFS_CTL1 8'h00
`define ADC_OFS_CTL2 8'h04
`define ADC_OFS_RES_LO 8'h08
`define ADC_OFS_RES_HI 8'h0C
`define ADC_OFS_PTR_LO 8'h10
`define ADC_OFS_PTR_HI 8'h14
`define ADC_OFS_PTR_PG 8'h18
`define ADC_OFS_IRQ_ST 8'h1C
`define ADC_OFS_IRQ_MSK 8'h20
// field positions
`define ADC_CTL2_DONE 7
`define ADC_CTL2_DMA 6
`define ADC_CTL2_SINGLE 4
`define ADC_CTL1_EXTTRIG 7
`define ADC_IRQ_TABLE 0
`define ADC_IRQ_SINGLE 1
// values
`define ADC_CH_STOP 4'hF
`define ADC_ENTRY_BYTES 24'h000002
`define ADC_RST_BYTE 8'h00
`define ADC_RESP_OKAY 2'h0
`define ADC_RESP_SLVERR 2'h2
// timing
`define ADC_CLK_MHZ 100
`define ADC_SAMPLE_MIN_NS 5000
`define ADC_SAMPLE_MIN_CYC ((`ADC_SAMPLE_MIN_NS * `ADC_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/adc_pkg.sv
package adc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_CHECK, ST_TRIG, ST_CONV, ST_WR_HI, ST_WR_LO
    } adc_state_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } adc_mem_req_t;

    typedef struct packed {
        logic [3:0] ch;
        logic [11:0] value;
    } adc_result_t;
endpackage

// >>> test/adc_sram_model.sv
`timescale 1ns/1ns
module adc_sram_model
(
    input wire logic clk,
    input wire logic [23:0] addr,
    input wire logic we_n,
    input wire logic rd_n,
    input wire logic [7:0] d_o,
    input wire logic d_oe,
    output logic [7:0] d_i
);
    logic [7:0] mem [int unsigned];
    logic [7:0] rd_q = 8'h00;
    logic rd_v = 1'b0;
    logic [7:0] last = 8'h00;
    ////////////////////////////////////////
    // no pull on port 0: an idle bus shows the inverse of its last level
    always_comb
    begin
        d_i = rd_v ? rd_q : (d_oe ? d_o : ~last);
    end
    // read data answers one cycle after the strobe
    always @(posedge clk)
    begin
        rd_v <= !rd_n;
        last <= d_i;
        if (!rd_n)
        begin
            rd_q <= mem.exists(addr) ? mem[addr] : 8'hFF;
        end
        if (!we_n)
        begin
            mem[addr] = d_o;
        end
    end
endmodule

// >>> test/adc_dma_capture_tb.sv
`timescale 1ns/1ns
`include "adc_regs.svh"
module adc_dma_capture_tb;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] aw_a = 8'h00;
    logic aw_v = 1'b0;
    logic [31:0] wd = 32'h0;
    logic w_v = 1'b0;
    logic b_r = 1'b0;
    logic [7:0] ar_a = 8'h00;
    logic ar_v = 1'b0;
    logic r_r = 1'b0;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, conv_st, p0_oe, we_n, rd_n, irq;
    logic [1:0] b_resp, r_resp, resp;
    logic [31:0] rd, rv;
    logic [3:0] conv_ch, cur;
    logic conv_dn = 1'b0;
    logic trg = 1'b0;
    logic [11:0] conv_d = 12'h000;
    logic [7:0] p0_o, p0_i, p2_o, a_lo, a_pg;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int t0 = 0;
    int cnt = 0;
    int n;
    logic [3:0] chs [$];
    logic [3:0] tbl [5] = '{4'h2, 4'h5, 4'h8, 4'h3, 4'hF};
    localparam logic [23:0] B1 = 24'h0A0B10;
    localparam logic [23:0] B2 = 24'h0A0B40;
    always #5 CLK = ~CLK;
    adc_dma_capture u_dut (.CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(aw_a),
        .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v),
        .S_AXI_RREADY(r_r), .CONV_START(conv_st), .CONV_CH(conv_ch),
        .CONV_DONE(conv_dn), .CONV_DATA(conv_d), .EXT_TRIG(trg),
        .CORE_P0_O(8'h3C), .CORE_P0_OE(1'b1), .CORE_P2_O(8'h77),
        .P0_O(p0_o), .P0_OE(p0_oe), .P0_I(p0_i), .P2_O(p2_o),
        .MEM_ADDR_LO(a_lo), .MEM_ADDR_PG(a_pg), .MEM_WE_N(we_n),
        .MEM_RD_N(rd_n), .IRQ(irq));
    adc_sram_model u_mem (.clk(CLK), .addr({a_pg, p2_o, a_lo}), .we_n(we_n),
        .rd_n(rd_n), .d_o(p0_o), .d_oe(p0_oe), .d_i(p0_i));
    ////////////////////////////////////////
    function automatic logic [11:0] smp(input logic [3:0] c);
        return {~c, 4'h5, c};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        aw_a <= a;
        aw_v <= 1'b1;
        wd <= d;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge CLK);
            if (aw_rdy === 1'b1 && aw_v)
            begin
                ad = 1'b1;
                aw_v <= 1'b0;
            end
            if (w_rdy === 1'b1 && w_v)
            begin
                dd = 1'b1;
                w_v <= 1'b0;
            end
        end
        do @(posedge CLK); while (b_v !== 1'b1);
        resp = b_resp;
        b_r <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do @(posedge CLK); while (ar_rdy !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge CLK); while (r_v !== 1'b1);
        rv = rd;
        resp = r_resp;
        r_r <= 1'b0;
        @(posedge CLK);
        chk(nm, e, rv);
    endtask
    task automatic close_out;
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    // analog front end stand-in; data lines toggle outside the done pulse
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cnt == 1)
        begin
            conv_dn <= 1'b1;
            conv_d <= smp(cur);
        end
        else
        begin
            conv_dn <= 1'b0;
            conv_d <= ~conv_d;
        end
        if (cnt > 0)
            cnt = cnt - 1;
        if (conv_st === 1'b1)
        begin
            chs.push_back(conv_ch);
            if (chs.size() > 1)
                chk("gap", 1, 32'(cyc - t0 >= `ADC_SAMPLE_MIN_CYC));
            t0 = cyc;
            cnt = 20;
            cur = conv_ch;
        end
        if (we_n === 1'b0 || rd_n === 1'b0)
            chk("bus addr", 16'h0A0B, {a_pg, p2_o});
        if (rd_n === 1'b0)
            chk("p0 oe", 0, p0_oe);
    end
    initial
    begin
        repeat (12) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        for (int i = 0; i < 9; i++)
            rc("reset", 8'(4 * i), 0);
        rc("unmapped", 8'h40, 0);
        chk("slverr", `ADC_RESP_SLVERR, resp);
        wr(8'h40, 32'h01);
        chk("wr slverr", `ADC_RESP_SLVERR, resp);
        for (int i = 0; i < 5; i++)
        begin
            u_mem.mem[B1 + 24'(2 * i)] = {tbl[i], 4'h0};
            u_mem.mem[B1 + 24'(2 * i + 1)] = 8'hC3;
        end
        wr(`ADC_OFS_PTR_LO, 32'h10);
        wr(`ADC_OFS_PTR_HI, 32'h0B);
        wr(`ADC_OFS_PTR_PG, 32'h0A);
        wr(`ADC_OFS_CTL1, 32'h01);
        wr(`ADC_OFS_IRQ_MSK, 32'h01);
        wr(`ADC_OFS_CTL2, 32'h40);
        wr(`ADC_OFS_PTR_LO, 32'hFF);
        rc("ptr locked", `ADC_OFS_PTR_LO, 32'h10);
        rc("enabled", `ADC_OFS_CTL2, 32'h40);
        n = 0;
        while (irq !== 1'b1 && n < 5000)
        begin
            @(posedge CLK);
            n++;
        end
        chk("irq", 1, irq);
        rc("done", `ADC_OFS_CTL2, 32'h80);
        chk("convs", 4, chs.size());
        for (int i = 0; i < 4; i++)
        begin
            chk("order", tbl[i], chs[i]);
            chk("ram hi", {tbl[i], ~tbl[i]}, u_mem.mem[B1 + 24'(2 * i)]);
            chk("ram lo", {4'h5, tbl[i]}, u_mem.mem[B1 + 24'(2 * i + 1)]);
        end
        chk("stop hi", 8'hF0, u_mem.mem[B1 + 24'h8]);
        chk("stop lo", 8'hC3, u_mem.mem[B1 + 24'h9]);
        rc("res hi", `ADC_OFS_RES_HI, 32'h3C);
        rc("res lo", `ADC_OFS_RES_LO, 32'h53);
        chk("p2 core", 8'h77, p2_o);
        wr(`ADC_OFS_IRQ_ST, 32'h01);
        chk("irq clr", 0, irq);
        // stop code first: capture must end with no conversion at all
        u_mem.mem[B2] = 8'hF0;
        wr(`ADC_OFS_PTR_LO, 32'h40);
        wr(`ADC_OFS_PTR_HI, 32'h0B);
        wr(`ADC_OFS_PTR_PG, 32'h0A);
        wr(`ADC_OFS_IRQ_MSK, 32'h00);
        wr(`ADC_OFS_CTL2, 32'h40);
        repeat (20) @(posedge CLK);
        rc("stop done", `ADC_OFS_CTL2, 32'h80);
        chk("masked", 0, irq);
        chk("no conv", 4, chs.size());
        wr(`ADC_OFS_IRQ_MSK, 32'h01);
        chk("unmasked", 1, irq);
        wr(`ADC_OFS_IRQ_ST, 32'h01);
        chk("cleared", 0, irq);
        // single conversion on the external trigger; nothing moves until it comes
        wr(`ADC_OFS_CTL1, 32'h81);
        wr(`ADC_OFS_CTL2, 32'h16);
        repeat (600) @(posedge CLK);
        chk("no trig", 4, chs.size());
        trg <= 1'b1;
        repeat (600) @(posedge CLK);
        chk("single", 5, chs.size());
        chk("single ch", 4'h6, chs[4]);
        rc("single st", `ADC_OFS_IRQ_ST, 32'h02);
        rc("single hi", `ADC_OFS_RES_HI, 32'h69);
        rc("single lo", `ADC_OFS_RES_LO, 32'h56);
        rc("single clr", `ADC_OFS_CTL2, 32'h06);
        close_out;
    end
    initial
    begin
        repeat (20000) @(posedge CLK);
        err_count++;
        close_out;
    end
endmodule
